// *** core/framer_pkg.sv ***
// ============================================================
// shared constants for the serial api frame builder
// ============================================================
// holds frame layout, type codes, status encodings and fifo sizing.
// assumes nothing beyond a systemverilog compiler.
package framer_pkg;

  // ============================================================
  // framing
  // ============================================================
  localparam logic [7:0]  FRAME_DELIM      = 8'h7e;
  localparam logic [7:0]  CSUM_BASE        = 8'hff;
  localparam logic [7:0]  TYPE_CMD_RSP     = 8'h88;
  localparam logic [7:0]  TYPE_MODEM_STAT  = 8'h8a;
  localparam logic [7:0]  FRAME_ID_NONE    = 8'h00;

  // ============================================================
  // length field values (bytes between length and checksum)
  // ============================================================
  localparam logic [15:0] LEN_CMD_RSP_BASE = 16'h0005;
  localparam logic [15:0] LEN_MODEM_STAT   = 16'h0002;

  // body byte positions after the type byte, for a command response
  localparam int          BODY_ID_POS      = 0;
  localparam int          BODY_CMD_HI_POS  = 1;
  localparam int          BODY_CMD_LO_POS  = 2;
  localparam int          BODY_STATUS_POS  = 3;
  localparam int          BODY_HDR_BYTES   = 4;

  // ============================================================
  // command response status byte
  // ============================================================
  localparam logic [7:0]  CMD_OK           = 8'h00;
  localparam logic [7:0]  CMD_ERROR        = 8'h01;
  localparam logic [7:0]  CMD_BAD_COMMAND  = 8'h02;
  localparam logic [7:0]  CMD_BAD_PARAM    = 8'h03;
  localparam logic [7:0]  CMD_TX_FAILURE   = 8'h04;

  // ============================================================
  // modem status codes
  // ============================================================
  localparam logic [7:0]  STAT_HW_RESET    = 8'h00;
  localparam logic [7:0]  STAT_WDOG_RESET  = 8'h01;
  localparam logic [7:0]  STAT_JOINED      = 8'h02;
  localparam logic [7:0]  STAT_DISASSOC    = 8'h03;
  localparam logic [7:0]  STAT_COORD_START = 8'h06;
  localparam logic [7:0]  STAT_KEY_UPDATE  = 8'h07;
  localparam logic [7:0]  STAT_SUPPLY_LIM  = 8'h0d;
  localparam logic [7:0]  STAT_CFG_IN_JOIN = 8'h11;
  localparam logic [7:0]  STAT_STACK_ERR   = 8'h80;

  // ============================================================
  // sizing
  // ============================================================
  localparam int          BYTE_W           = 8;
  localparam int          FIFO_DEPTH       = 16;
  localparam int          MAX_VALUE_BYTES  = 8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DELIM,
    ST_LEN_HI,
    ST_LEN_LO,
    ST_TYPE,
    ST_BODY,
    ST_CSUM
  } frame_state_t;

  // one's complement style frame checksum over the running sum
  function automatic logic [7:0] frame_csum(input logic [7:0] sum);
    return CSUM_BASE - sum;
  endfunction

endpackage

// *** core/byte_stream_if.sv ***
// ============================================================
// byte stream carrier between framer and output fifo
// ============================================================
// valid/ready handshake; a byte moves on a clock edge with both high.
// assumes both ends share one clock.
interface byte_stream_if #(
  parameter int WIDTH = 8
);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface

// *** core/byte_fifo.sv ***
// ============================================================
// synchronous fifo with registered read data
// ============================================================
// holds DEPTH words in memory plus one output register.
// assumes one clock and an asynchronous active-low reset.
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic     clock_i,
  input  wire logic     reset_n_i,
  // streams
  byte_stream_if.sink   wr,
  byte_stream_if.source rd
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = AW'(DEPTH) == '0 ? {1'b1, {AW{1'b0}}} : (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW-1:0]    rd_ptr_next;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic [WIDTH-1:0] out_data_reg;
  logic [WIDTH-1:0] out_data_next;
  logic             out_valid_reg;
  logic             out_valid_next;
  logic             push;
  logic             pop;

  // ready is honest full: back-pressure reaches the framer
  assign wr.ready = (count_reg != FULL_COUNT);
  assign rd.data  = out_data_reg;
  assign rd.valid = out_valid_reg;
  assign push     = wr.valid && wr.ready;
  // refill output register when empty or being taken
  assign pop      = (count_reg != '0) && (!out_valid_reg || rd.ready);

  always_comb begin
    wr_ptr_next    = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next    = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next     = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    out_data_next  = pop ? mem[rd_ptr_reg] : out_data_reg;
    out_valid_next = pop ? 1'b1 : (rd.ready ? 1'b0 : out_valid_reg);
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= wr.data;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      count_reg     <= '0;
      out_data_reg  <= '0;
      out_valid_reg <= 1'b0;
    end else begin
      wr_ptr_reg    <= wr_ptr_next;
      rd_ptr_reg    <= rd_ptr_next;
      count_reg     <= count_next;
      out_data_reg  <= out_data_next;
      out_valid_reg <= out_valid_next;
    end
  end
endmodule

// *** core/api_response_status_framer.sv ***
// ============================================================
// serial api frame builder: command responses and modem status
// ============================================================
// builds delimited, length-prefixed, checksummed frames into a byte fifo.
// assumes a serial transmitter drains tx_* and command/status logic
// on the same clock presents requests with valid/ready.
//
// Overview of operation
// - frame opens with 0x7e, then a two-byte length, high byte first
// - last byte is 0xff minus the low byte sum from type byte onward
// - a processed command yields a response frame of type 0x88
// - one request yields at most one response frame, even with a repeated identifier
// - byte four of the response echoes the request identifier
// - a request with identifier zero produces no response frame
// - bytes five and six repeat the two command characters in order
// - status byte seven: ok, error, bad command, bad parameter, tx failure
// - queried value follows status; omitted on writes, length shrinks to match
// - device-initiated status frame has type 0x8a and length two
// - status code at byte four carries the documented condition codes
module api_response_status_framer
  import framer_pkg::*;
#(
  parameter int VALUE_BYTES = framer_pkg::MAX_VALUE_BYTES,
  parameter int DEPTH       = framer_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                               clock_i,
  input  wire logic                               reset_n_i,
  // command response request
  input  wire logic                               rsp_valid_i,
  output logic                                    rsp_ready_o,
  input  wire logic [framer_pkg::BYTE_W-1:0]      rsp_frame_id_i,
  input  wire logic [framer_pkg::BYTE_W-1:0]      rsp_cmd_hi_i,
  input  wire logic [framer_pkg::BYTE_W-1:0]      rsp_cmd_lo_i,
  input  wire logic [framer_pkg::BYTE_W-1:0]      rsp_status_i,
  input  wire logic                               rsp_is_write_i,
  input  wire logic [3:0]                         rsp_value_len_i,
  input  wire logic [VALUE_BYTES*8-1:0]           rsp_value_i,
  // modem status request
  input  wire logic                               stat_valid_i,
  output logic                                    stat_ready_o,
  input  wire logic [framer_pkg::BYTE_W-1:0]      stat_code_i,
  // serial byte output
  output logic [framer_pkg::BYTE_W-1:0]           tx_data_o,
  output logic                                    tx_valid_o,
  input  wire logic                               tx_ready_i,
  // event pulses
  output logic                                    frame_done_o,
  output logic                                    rsp_dropped_o
);
  import framer_pkg::*;

  localparam int BODY_BYTES = BODY_HDR_BYTES + VALUE_BYTES;
  localparam int IDX_W      = $clog2(BODY_BYTES + 1);
  // a status frame carries only the code after its type byte
  localparam int STAT_BODY_BYTES = 1;

  // ============================================================
  // state
  // ============================================================
  frame_state_t          state_reg;
  frame_state_t          state_next;
  logic [15:0]           len_reg;
  logic [15:0]           len_next;
  logic [7:0]            type_reg;
  logic [7:0]            type_next;
  logic [BODY_BYTES*8-1:0] body_reg;
  logic [BODY_BYTES*8-1:0] body_next;
  logic [IDX_W-1:0]      body_cnt_reg;
  logic [IDX_W-1:0]      body_cnt_next;
  logic [IDX_W-1:0]      idx_reg;
  logic [IDX_W-1:0]      idx_next;
  logic [7:0]            sum_reg;
  logic [7:0]            sum_next;
  logic                  rsp_ready_reg;
  logic                  rsp_ready_next;
  logic                  stat_ready_reg;
  logic                  stat_ready_next;
  logic                  done_reg;
  logic                  done_next;
  logic                  dropped_reg;
  logic                  dropped_next;

  logic [7:0]            cur_byte;
  logic                  fire;
  logic                  take_rsp;
  logic                  take_stat;
  logic [IDX_W-1:0]      value_cnt;

  byte_stream_if #(.WIDTH(BYTE_W)) fifo_in ();
  byte_stream_if #(.WIDTH(BYTE_W)) fifo_out ();

  // ============================================================
  // output buffer
  // ============================================================
  byte_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .wr        (fifo_in.sink),
    .rd        (fifo_out.source)
  );

  assign fifo_in.data   = cur_byte;
  assign fifo_in.valid  = (state_reg != ST_IDLE);
  assign fifo_out.ready = tx_ready_i;
  assign fire           = fifo_in.valid && fifo_in.ready;

  // status wins when both wait: it is short and rare
  assign take_stat = stat_valid_i && stat_ready_reg;
  assign take_rsp  = rsp_valid_i && rsp_ready_reg && !stat_valid_i;

  // ============================================================
  // value length
  // ============================================================
  // a value longer than the port is clipped to the port's size;
  // a write answers with no value at all, so the length shrinks
  function automatic logic [IDX_W-1:0] clip_value_len(
    input logic       is_write,
    input logic [3:0] req_len
  );
    logic [IDX_W-1:0] n;
    n = IDX_W'(req_len);
    if (is_write) begin
      n = '0;
    end else if (n > IDX_W'(VALUE_BYTES)) begin
      n = IDX_W'(VALUE_BYTES);
    end
    return n;
  endfunction

  assign value_cnt = clip_value_len(rsp_is_write_i, rsp_value_len_i);

  // ============================================================
  // byte selection
  // ============================================================
  always_comb begin
    cur_byte = '0;
    unique case (state_reg)
      ST_IDLE:   cur_byte = '0;
      ST_DELIM:  cur_byte = FRAME_DELIM;
      ST_LEN_HI: cur_byte = len_reg[15:8];
      ST_LEN_LO: cur_byte = len_reg[7:0];
      ST_TYPE:   cur_byte = type_reg;
      ST_BODY:   cur_byte = body_reg[idx_reg*8 +: 8];
      ST_CSUM:   cur_byte = frame_csum(sum_reg);
    endcase
  end

  // ============================================================
  // framing sequence
  // ============================================================
  always_comb begin
    state_next    = state_reg;
    len_next      = len_reg;
    type_next     = type_reg;
    body_next     = body_reg;
    body_cnt_next = body_cnt_reg;
    idx_next      = idx_reg;
    sum_next      = sum_reg;
    done_next     = 1'b0;
    dropped_next  = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (take_stat) begin
          type_next     = TYPE_MODEM_STAT;
          len_next      = LEN_MODEM_STAT;
          body_next     = '0;
          // any code passes through unchanged, known or not
          body_next[7:0] = stat_code_i;
          body_cnt_next = IDX_W'(STAT_BODY_BYTES);
          state_next    = ST_DELIM;
        end else if (take_rsp) begin
          if (rsp_frame_id_i == FRAME_ID_NONE) begin
            dropped_next = 1'b1;
          end else begin
            type_next = TYPE_CMD_RSP;
            body_next = '0;
            body_next[BODY_ID_POS*8 +: 8]     = rsp_frame_id_i;
            body_next[BODY_CMD_HI_POS*8 +: 8] = rsp_cmd_hi_i;
            body_next[BODY_CMD_LO_POS*8 +: 8] = rsp_cmd_lo_i;
            body_next[BODY_STATUS_POS*8 +: 8] = rsp_status_i;
            body_next[BODY_HDR_BYTES*8 +: VALUE_BYTES*8] = rsp_value_i;
            body_cnt_next = IDX_W'(BODY_HDR_BYTES) + value_cnt;
            len_next      = LEN_CMD_RSP_BASE + 16'(value_cnt);
            state_next    = ST_DELIM;
          end
        end
      end
      ST_DELIM: begin
        if (fire) begin
          state_next = ST_LEN_HI;
        end
      end
      ST_LEN_HI: begin
        if (fire) begin
          state_next = ST_LEN_LO;
        end
      end
      ST_LEN_LO: begin
        if (fire) begin
          state_next = ST_TYPE;
        end
      end
      ST_TYPE: begin
        if (fire) begin
          sum_next   = type_reg;
          idx_next   = '0;
          state_next = ST_BODY;
        end
      end
      ST_BODY: begin
        if (fire) begin
          sum_next = sum_reg + cur_byte;
          idx_next = idx_reg + 1'b1;
          if (idx_reg + 1'b1 == body_cnt_reg) begin
            state_next = ST_CSUM;
          end
        end
      end
      ST_CSUM: begin
        if (fire) begin
          done_next  = 1'b1;
          state_next = ST_IDLE;
        end
      end
    endcase
    // accept a new request only while idle; each request with a nonzero
    // identifier, even a repeated one, gets its own frame
    rsp_ready_next  = (state_next == ST_IDLE) && !take_rsp && !take_stat;
    stat_ready_next = (state_next == ST_IDLE) && !take_rsp && !take_stat;
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg      <= ST_IDLE;
      len_reg        <= '0;
      type_reg       <= '0;
      body_reg       <= '0;
      body_cnt_reg   <= '0;
      idx_reg        <= '0;
      sum_reg        <= '0;
      rsp_ready_reg  <= 1'b0;
      stat_ready_reg <= 1'b0;
      done_reg       <= 1'b0;
      dropped_reg    <= 1'b0;
    end else begin
      state_reg      <= state_next;
      len_reg        <= len_next;
      type_reg       <= type_next;
      body_reg       <= body_next;
      body_cnt_reg   <= body_cnt_next;
      idx_reg        <= idx_next;
      sum_reg        <= sum_next;
      rsp_ready_reg  <= rsp_ready_next;
      stat_ready_reg <= stat_ready_next;
      done_reg       <= done_next;
      dropped_reg    <= dropped_next;
    end
  end

  // ============================================================
  // outputs
  // ============================================================
  assign rsp_ready_o   = rsp_ready_reg;
  assign stat_ready_o  = stat_ready_reg;
  assign tx_data_o     = fifo_out.data;
  assign tx_valid_o    = fifo_out.valid;
  assign frame_done_o  = done_reg;
  assign rsp_dropped_o = dropped_reg;

endmodule

// *** sim/framer_properties.sv ***
// =============================================================
// port-level properties of the frame builder
// =============================================================
// sees only top-level ports; bound in at the foot of this file.
// assumes one clock domain with async active-low reset.
module framer_properties (
  // clock and reset
  input wire logic       clock_i,
  input wire logic       reset_n_i,
  // requests
  input wire logic       rsp_valid_i,
  input wire logic       rsp_ready_o,
  input wire logic [7:0] rsp_frame_id_i,
  input wire logic       stat_valid_i,
  input wire logic       stat_ready_o,
  // output stream and events
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_valid_o,
  input wire logic       tx_ready_i,
  input wire logic       frame_done_o,
  input wire logic       rsp_dropped_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // status wins a tie, so a response is only taken alone
  sequence s_stat_take; stat_valid_i && stat_ready_o; endsequence
  sequence s_rsp_take; rsp_valid_i && rsp_ready_o && !stat_valid_i; endsequence
  property p_rsp_busy; s_rsp_take |=> !rsp_ready_o; endproperty
  a_rsp_busy: assert property (p_rsp_busy) else $error("ready stayed high after take");
  property p_drop_zero;
    s_rsp_take ##0 (rsp_frame_id_i == 8'h00) |=> rsp_dropped_o ##1 !rsp_dropped_o;
  endproperty
  a_drop_zero: assert property (p_drop_zero) else $error("zero id not dropped");
  property p_keep_id; s_rsp_take ##0 (rsp_frame_id_i != 8'h00) |=> !rsp_dropped_o; endproperty
  a_keep_id: assert property (p_keep_id) else $error("nonzero id dropped");
  property p_stat_busy; s_stat_take |=> !stat_ready_o && !rsp_dropped_o; endproperty
  a_stat_busy: assert property (p_stat_busy) else $error("status take mishandled");
  property p_tx_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte changed while stalled");
  property p_done_pulse; frame_done_o |=> !frame_done_o; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("frame done too long");
  property p_ready_back; frame_done_o |-> ##[0:1] (rsp_ready_o && stat_ready_o); endproperty
  a_ready_back: assert property (p_ready_back) else $error("ready not back after frame");
  property p_drop_ready; rsp_dropped_o |-> ##[0:2] rsp_ready_o; endproperty
  a_drop_ready: assert property (p_drop_ready) else $error("ready not back after drop");
endmodule
bind api_response_status_framer framer_properties framer_properties_inst (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .rsp_valid_i(rsp_valid_i),
  .rsp_ready_o(rsp_ready_o), .rsp_frame_id_i(rsp_frame_id_i), .stat_valid_i(stat_valid_i),
  .stat_ready_o(stat_ready_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
  .tx_ready_i(tx_ready_i), .frame_done_o(frame_done_o), .rsp_dropped_o(rsp_dropped_o));

// *** sim/host_link_model.sv ***
// =============================================================
// host side: byte sink that parses frames
// =============================================================
// accepts bytes with random back-pressure, counts good and bad frames.
// assumes the tb seeds $urandom once.
module host_link_model (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  // byte stream
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  // control and results
  input  wire logic       stall_i,
  output int              good_o,
  output int              bad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int         pos, cnt;
  logic [15:0] len;
  logic [7:0]  sum;
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_ready_o <= 1'b0;
      pos <= 0;
      good_o <= 0;
      bad_o <= 0;
    end else begin
      tx_ready_o <= !stall_i && ($urandom % 4 != 0);
      if (tx_valid_i && tx_ready_o) begin
        case (pos)
          0: if (tx_data_i == 8'h7e) pos <= 1;
          1: begin len[15:8] <= tx_data_i; pos <= 2; end
          2: begin len[7:0] <= tx_data_i; cnt <= 0; sum <= 8'h00; pos <= 3; end
          default: begin
            // any type or status code is accepted as payload
            if (cnt == int'(len)) begin
              if (8'(sum + tx_data_i) == 8'hff) good_o <= good_o + 1;
              else bad_o <= bad_o + 1;
              pos <= 0;
            end else begin
              sum <= sum + tx_data_i;
              cnt <= cnt + 1;
            end
          end
        endcase
      end
    end
  end
endmodule

// *** sim/tb_top.sv ***
// =============================================================
// self-checking bench for the frame builder
// =============================================================
// drives requests, queues expected bytes, compares the tx stream.
// assumes host_link_model and the bound checker are compiled.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import framer_pkg::*;
  logic clock_i, reset_n_i, rsp_valid_i, rsp_ready_o, rsp_is_write_i, stat_valid_i;
  logic stat_ready_o, tx_valid_o, tx_ready_i, frame_done_o, rsp_dropped_o, stall;
  logic [7:0]  rsp_frame_id_i, rsp_cmd_hi_i, rsp_cmd_lo_i, rsp_status_i, stat_code_i, tx_data_o;
  logic [3:0]  rsp_value_len_i;
  logic [63:0] rsp_value_i;
  logic [7:0]  exp_q[$];
  logic [7:0]  codes[11] = '{STAT_HW_RESET, STAT_WDOG_RESET, STAT_JOINED, STAT_DISASSOC,
    STAT_COORD_START, STAT_KEY_UPDATE, STAT_SUPPLY_LIM, STAT_CFG_IN_JOIN, STAT_STACK_ERR,
    8'hff, 8'h55};
  int n_errors, checks_done, frames_exp, cycles, good, bad, k;
  api_response_status_framer #(.VALUE_BYTES(8), .DEPTH(16)) api_response_status_framer_inst (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .rsp_valid_i(rsp_valid_i),
    .rsp_ready_o(rsp_ready_o), .rsp_frame_id_i(rsp_frame_id_i), .rsp_cmd_hi_i(rsp_cmd_hi_i),
    .rsp_cmd_lo_i(rsp_cmd_lo_i), .rsp_status_i(rsp_status_i), .rsp_is_write_i(rsp_is_write_i),
    .rsp_value_len_i(rsp_value_len_i), .rsp_value_i(rsp_value_i), .stat_valid_i(stat_valid_i),
    .stat_ready_o(stat_ready_o), .stat_code_i(stat_code_i), .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .frame_done_o(frame_done_o),
    .rsp_dropped_o(rsp_dropped_o));
  host_link_model host_link_model_inst (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i),
    .stall_i(stall), .good_o(good), .bad_o(bad));
  // =============================================================
  // clock, timeout, checking
  // =============================================================
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  task test_done;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done;
    end
  end
  // monitor: every accepted byte takes the oldest note
  always @(posedge clock_i) begin
    if (reset_n_i && tx_valid_o && tx_ready_i) begin
      if (exp_q.size() == 0) chk("tx_data_o extra", {24'h0, tx_data_o}, 32'hffff_ffff);
      else chk("tx_data_o", {24'h0, tx_data_o}, {24'h0, exp_q.pop_front()});
    end
  end
  // =============================================================
  // drivers
  // =============================================================
  task automatic push_frame(input logic [7:0] body[$]);
    logic [7:0] sum;
    sum = 8'h00;
    exp_q.push_back(8'h7e);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'(body.size()));
    foreach (body[i]) begin
      exp_q.push_back(body[i]);
      sum += body[i];
    end
    exp_q.push_back(8'hff - sum);
    frames_exp++;
  endtask
  task automatic send_rsp(input logic [7:0] id, hi, lo, st, input logic wr, input logic [3:0] n,
                input logic [63:0] v);
    logic [7:0] b[$];
    int w;
    @(posedge clock_i);
    {rsp_frame_id_i, rsp_cmd_hi_i, rsp_cmd_lo_i, rsp_status_i} <= {id, hi, lo, st};
    {rsp_is_write_i, rsp_value_len_i, rsp_value_i, rsp_valid_i} <= {wr, n, v, 1'b1};
    w = 0;
    do begin @(posedge clock_i); w++; end while (!(rsp_ready_o && !stat_valid_i) && w < 400);
    rsp_valid_i <= 1'b0;
    b = '{8'h88, id, hi, lo, st};
    if (!wr) for (int i = 0; i < n; i++) b.push_back(v[8*i +: 8]);
    if (id != 8'h00) push_frame(b);
  endtask
  task automatic send_stat(input logic [7:0] code);
    int w;
    @(posedge clock_i);
    stat_code_i <= code;
    stat_valid_i <= 1'b1;
    w = 0;
    do begin @(posedge clock_i); w++; end while (!stat_ready_o && w < 400);
    stat_valid_i <= 1'b0;
    push_frame('{8'h8a, code});
  endtask
  // =============================================================
  // main sequence
  // =============================================================
  initial begin
    {reset_n_i, rsp_valid_i, rsp_is_write_i, stat_valid_i, stall} = '0;
    {rsp_frame_id_i, rsp_cmd_hi_i, rsp_cmd_lo_i, rsp_status_i, stat_code_i} = '0;
    rsp_value_len_i = 4'h0;
    rsp_value_i = 64'h0;
    void'($urandom(33));
    repeat (6) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    send_rsp(8'h01, 8'h42, 8'h44, CMD_OK, 1'b1, 4'h0, 64'h0);
    for (int s = 0; s < 5; s++)
      send_rsp(8'($urandom_range(255, 1)), 8'h41, 8'h5a, 8'(s), 1'b0,
               (s == 4) ? 4'h8 : 4'(s), {$urandom, $urandom});
    send_rsp(8'h00, 8'h41, 8'h49, CMD_OK, 1'b0, 4'h2, 64'h1234);
    repeat (2) send_rsp(8'h37, 8'h4e, 8'h44, CMD_OK, 1'b0, 4'h8, {$urandom, $urandom});
    // hold the host off so the fifo fills and the framer must wait
    stall <= 1'b1;
    fork
      begin
        repeat (80) @(posedge clock_i);
        stall <= 1'b0;
      end
    join_none
    foreach (codes[i]) send_stat(codes[i]);
    fork // status wins a same-cycle tie
      send_stat(STAT_JOINED);
      send_rsp(8'h09, 8'h42, 8'h44, CMD_BAD_PARAM, 1'b1, 4'h3, 64'hff);
    join
    k = 0;
    while (exp_q.size() != 0 && k < 3000) begin @(posedge clock_i); k++; end
    repeat (8) @(posedge clock_i);
    chk("exp_q drained", exp_q.size(), 0);
    chk("good frames", good, frames_exp);
    chk("bad frames", bad, 0);
    test_done;
  end
endmodule
